// >>> verif/hzm_machine.sv
`timescale 1ns/100ps
// -------------------------------------------
// moulding machine cycle source
// -------------------------------------------
module hzm_machine (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      cycle_in
);
  int cnt_q = 0;
  initial cycle_in = 1'b0;
  // one-cycle pulse every 8 cycles while cycling, quiet when stopped
  always @(posedge clk_sys) begin
    cnt_q    <= run ? (cnt_q + 1) % 8 : 0;
    cycle_in <= run && cnt_q == 7;
  end
endmodule

// >>> verif/test_heater_zone_monitor.sv
`timescale 1ns/100ps
module test_heater_zone_monitor;
  import hzm_pkg::*;
  logic        clk_sys = 0, arst_n = 0, power_mon_en = 0, power_capture = 0, res_mon_en = 0;
  logic        res_capture = 0, res_base_nv_valid = 0, prot_en = 0, low_temp_alarm = 1, run = 0;
  logic        prot_time_wr = 0, prot_reset = 0, cyc_d = 0;
  logic [31:0] zone_power = '0, zone_res = '0, res_base_nv = '0, res_base_out;
  logic [6:0]  power_tol_pct = '0;
  logic [9:0]  prot_time_s = '0;
  hzm_edge_t   cycle_edge_sel = HZM_EDGE_RISE;
  logic        cycle_in, cycle_present, standby_req, prot_timeout;
  logic [1:0]  power_alarm, res_alarm;
  int          fails = 0, n_tests = 0;

  hzm_monitor #(.ZONES(2), .DW(16), .SEC_CYC(10)) u_hzm_monitor (.clk_sys(clk_sys), .arst_n(arst_n),
    .zone_power(zone_power), .zone_res(zone_res), .power_tol_pct(power_tol_pct), .power_mon_en(power_mon_en),
    .power_capture(power_capture), .res_mon_en(res_mon_en), .res_capture(res_capture),
    .res_base_nv(res_base_nv), .res_base_nv_valid(res_base_nv_valid), .prot_en(prot_en),
    .cycle_edge_sel(cycle_edge_sel), .cycle_in(cycle_in), .low_temp_alarm(low_temp_alarm),
    .prot_time_s(prot_time_s), .prot_time_wr(prot_time_wr), .prot_reset(prot_reset),
    .power_alarm(power_alarm), .res_alarm(res_alarm), .res_base_out(res_base_out),
    .cycle_present(cycle_present), .standby_req(standby_req), .prot_timeout(prot_timeout));
  hzm_machine u_hzm_machine (.clk_sys(clk_sys), .run(run), .cycle_in(cycle_in));

  initial forever #50 clk_sys = ~clk_sys;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic look();
    @(negedge clk_sys);
  endtask
  // bounded wait for the latched timeout
  task automatic wait_trip(int lim);
    int i;
    for (i = 0; i < lim && prot_timeout !== 1'b1; i++) look();
    if (i == lim) begin
      fails++;
      give_verdict();
    end
  endtask
  function automatic logic [15:0] scale(logic [15:0] v, logic [7:0] pct);
    logic [31:0] r;
    r = {16'h0, v} * (32'd100 + {24'h0, pct}) / 32'd100;
    return r > 32'hFFFF ? 16'hFFFF : r[15:0];
  endfunction

  // cycle_present trails cycle_in by one clock
  always @(posedge clk_sys) cyc_d <= cycle_in;
  always @(negedge clk_sys) if (arst_n) check("cycle_present", {31'h0, cycle_present}, {31'h0, cyc_d});

  initial begin
    logic [15:0] p, t;
    logic [6:0]  tol;
    void'($urandom(32'h3a719450));
    tick(5);
    arst_n <= 1'b1;
    look();
    check("res_base_out", res_base_out, 32'hFFFF_FFFF);
    for (int k = 0; k < 4; k++) begin
      p = 16'($urandom_range(32'h7FFF, 1));
      tol = (k == 0) ? 7'h00 : 7'($urandom_range(50));
      t = scale(p, {1'b0, tol});
      tick(1);
      zone_power <= {p, p};
      power_tol_pct <= tol;
      power_mon_en <= k[0];
      tick(1);
      power_capture <= 1'b1;
      tick(1);
      power_capture <= 1'b0;
      zone_power <= {t + 16'h0001, t};
      tick(3);
      look();
      check("power_alarm", {30'h0, power_alarm}, {30'h0, k[0], 1'b0});
    end
    p = 16'($urandom_range(32'h7FFF, 1));
    t = scale(p, 8'h28);
    tick(1);
    zone_res <= {p, p};
    res_mon_en <= 1'b1;
    tick(1);
    res_capture <= 1'b1;
    tick(1);
    res_capture <= 1'b0;
    zone_res <= {t + 16'h0001, t};
    tick(3);
    look();
    check("res_base_out", res_base_out, {p, p});
    check("res_alarm", {30'h0, res_alarm}, 32'h2);
    tick(1);
    res_mon_en <= 1'b0;
    res_base_nv <= $urandom;
    res_base_nv_valid <= 1'b1;
    tick(1);
    res_base_nv_valid <= 1'b0;
    tick(3);
    look();
    check("res_alarm", {30'h0, res_alarm}, 32'h0);
    check("res_base_out", res_base_out, res_base_nv);
    tick(1);
    prot_en <= 1'b1;
    tick(20);
    look();
    check("prot_timeout", {31'h0, prot_timeout}, 32'h0);
    tick(1);
    low_temp_alarm <= 1'b0;
    wait_trip(10);
    tick(30);
    look();
    check("prot_timeout", {31'h0, prot_timeout}, 32'h1);
    check("standby_req", {31'h0, standby_req}, 32'h1);
    for (int e = 0; e < 2; e++) begin
      tick(1);
      cycle_edge_sel <= hzm_edge_t'(e);
      prot_time_s <= 10'h002;
      prot_time_wr <= 1'b1;
      run <= 1'b1;
      tick(1);
      prot_time_wr <= 1'b0;
      prot_reset <= 1'b1;
      tick(1);
      prot_reset <= 1'b0;
      tick(60);
      look();
      check("prot_timeout", {31'h0, prot_timeout}, 32'h0);
      tick(1);
      run <= 1'b0;
      tick(12);
      look();
      check("prot_timeout", {31'h0, prot_timeout}, 32'h0);
      wait_trip(30);
    end
    tick(1);
    prot_en <= 1'b0;
    prot_reset <= 1'b1;
    prot_time_s <= 10'h3FF;
    prot_time_wr <= 1'b1;
    tick(1);
    prot_reset <= 1'b0;
    prot_time_wr <= 1'b0;
    tick(40);
    look();
    check("prot_timeout", {31'h0, prot_timeout}, 32'h0);
    give_verdict();
  end
endmodule

// >>> verilog/hzm_cfg.svh
`ifndef HZM_CFG_SVH
`define HZM_CFG_SVH
// resistance limit: baseline plus this percentage
`define HZM_RES_PCT      7'd40
// protection time range and default, whole seconds
`define HZM_PROT_MAX_S   10'd999
`define HZM_PROT_RST_S   10'd0
// clock rate and one second in clock cycles
`define HZM_CLK_HZ       10000000
`define HZM_SEC_CYC      (`HZM_CLK_HZ / 1)
`endif

// >>> verilog/hzm_monitor.sv
`timescale 1ns/100ps
`include "hzm_cfg.svh"
module hzm_monitor #(
  parameter int ZONES   = 8,
  parameter int DW      = 16,
  parameter int SEC_CYC = `HZM_SEC_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic [ZONES*DW-1:0]   zone_power,
  input  wire logic [ZONES*DW-1:0]   zone_res,
  input  wire logic [6:0]            power_tol_pct,
  input  wire logic                  power_mon_en,
  input  wire logic                  power_capture,
  input  wire logic                  res_mon_en,
  input  wire logic                  res_capture,
  input  wire logic [ZONES*DW-1:0]   res_base_nv,
  input  wire logic                  res_base_nv_valid,
  input  wire logic                  prot_en,
  input  wire hzm_pkg::hzm_edge_t    cycle_edge_sel,
  input  wire logic                  cycle_in,
  input  wire logic                  low_temp_alarm,
  input  wire logic [9:0]            prot_time_s,
  input  wire logic                  prot_time_wr,
  input  wire logic                  prot_reset,
  output logic [ZONES-1:0]           power_alarm,
  output logic [ZONES-1:0]           res_alarm,
  output logic [ZONES*DW-1:0]        res_base_out,
  output logic                       cycle_present,
  output logic                       standby_req,
  output logic                       prot_timeout
);
  import hzm_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // value plus pct percent, saturated; widened to avoid overflow
  function automatic logic [DW-1:0] add_pct(input logic [DW-1:0] v, input logic [6:0] pct);
    logic [DW+7:0] p;
    logic [DW+7:0] s;
    p = ({8'h00, v} * {{DW{1'b0}}, 1'b0, pct}) / (DW+8)'(100);
    s = {8'h00, v} + p;
    add_pct = (s > {8'h00, {DW{1'b1}}}) ? {DW{1'b1}} : s[DW-1:0];
  endfunction

  // ------------------------------------------------------------
  // power and resistance monitors
  // ------------------------------------------------------------
  logic [ZONES*DW-1:0] pthr_q;
  logic [ZONES*DW-1:0] rbase_q;
  logic [ZONES-1:0]    palarm_q;
  logic [ZONES-1:0]    ralarm_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pthr_q <= '1;
    end else if (power_capture) begin
      for (int i = 0; i < ZONES; i++) begin
        pthr_q[i*DW +: DW] <= add_pct(zone_power[i*DW +: DW], power_tol_pct);
      end
    end
  end

  // baseline mirror; the nonvolatile copy is outside, reloaded via res_base_nv
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rbase_q <= '1;
    end else if (res_capture) begin
      rbase_q <= zone_res;
    end else if (res_base_nv_valid) begin
      rbase_q <= res_base_nv;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      palarm_q <= '0;
      ralarm_q <= '0;
    end else begin
      for (int i = 0; i < ZONES; i++) begin
        palarm_q[i] <= power_mon_en && (zone_power[i*DW +: DW] > pthr_q[i*DW +: DW]);
        ralarm_q[i] <= res_mon_en &&
                       (zone_res[i*DW +: DW] > add_pct(rbase_q[i*DW +: DW], `HZM_RES_PCT));
      end
    end
  end

  assign power_alarm  = palarm_q;
  assign res_alarm    = ralarm_q;
  assign res_base_out = rbase_q;

  // ------------------------------------------------------------
  // material protection watchdog
  // ------------------------------------------------------------
  logic [9:0]  ptime_q;
  logic        cyc_q;
  logic        pres_q;
  logic [9:0]  sec_left_q;
  logic [31:0] tick_q;
  logic        stby_q;
  logic        tout_q;
  hzm_wd_t     wd_q;
  logic        cyc_evt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ptime_q <= `HZM_PROT_RST_S;
    end else if (prot_time_wr) begin
      ptime_q <= (prot_time_s > `HZM_PROT_MAX_S) ? `HZM_PROT_MAX_S : prot_time_s;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q  <= 1'b0;
      pres_q <= 1'b0;
    end else begin
      cyc_q  <= cycle_in;
      pres_q <= cycle_in;
    end
  end

  assign cyc_evt = (cycle_edge_sel == HZM_EDGE_RISE) ? (cycle_in && !cyc_q)
                                                     : (!cycle_in && cyc_q);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wd_q       <= HZM_WD_HOLD;
      sec_left_q <= '0;
      tick_q     <= '0;
      tout_q     <= 1'b0;
    end else if (!prot_en) begin
      wd_q   <= HZM_WD_HOLD;
      tout_q <= tout_q && !prot_reset;
    end else begin
      unique case (wd_q)
        HZM_WD_HOLD: begin
          sec_left_q <= ptime_q;
          tick_q     <= '0;
          // a latched timeout must be reset before the timer may run again
          if (prot_reset) tout_q <= 1'b0;
          if (!low_temp_alarm && !tout_q) wd_q <= HZM_WD_RUN;
        end
        HZM_WD_RUN: begin
          if (cyc_evt) begin
            sec_left_q <= ptime_q;
            tick_q     <= '0;
          end else if (sec_left_q == 10'd0) begin
            wd_q   <= HZM_WD_TRIP;
            tout_q <= 1'b1;
          end else if (tick_q == 32'(SEC_CYC - 1)) begin
            tick_q     <= '0;
            sec_left_q <= sec_left_q - 10'd1;
          end else begin
            tick_q <= tick_q + 32'd1;
          end
        end
        HZM_WD_TRIP: begin
          if (prot_reset) begin
            wd_q   <= HZM_WD_HOLD;
            tout_q <= 1'b0;
          end
        end
        default: wd_q <= HZM_WD_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stby_q <= 1'b0;
    end else begin
      stby_q <= prot_en && (wd_q == HZM_WD_TRIP);
    end
  end

  assign cycle_present = pres_q;
  assign standby_req   = stby_q;
  assign prot_timeout  = tout_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence trip_cond_s;
    prot_en && wd_q == HZM_WD_RUN && !cyc_evt && sec_left_q == 10'd0;
  endsequence

  power_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !$past(power_mon_en) |-> power_alarm == '0) else $error("power alarm while disabled");
  res_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !$past(res_mon_en) |-> res_alarm == '0) else $error("res alarm while disabled");
  res_capture_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    res_capture |=> res_base_out == $past(zone_res)) else $error("baseline not captured");
  presence_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 cycle_present == $past(cycle_in)) else $error("presence wrong");
  tout_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prot_timeout && !prot_reset |=> prot_timeout) else $error("timeout dropped");
  tout_clr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prot_timeout && prot_reset |=> !prot_timeout) else $error("timeout not cleared");
  ptime_max_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ptime_q <= `HZM_PROT_MAX_S) else $error("time over range");
  wd_enable_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !prot_en |=> !standby_req) else $error("standby while disabled");
  lowtemp_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wd_q == HZM_WD_HOLD && low_temp_alarm |=> wd_q == HZM_WD_HOLD) else $error("timer ran early");
  restart_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    prot_en && wd_q == HZM_WD_RUN && cyc_evt |=> sec_left_q == $past(ptime_q)) else $error("no restart");
  zero_trip_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trip_cond_s |=> prot_timeout ##1 standby_req) else $error("no trip");
endmodule

// >>> verilog/hzm_pkg.sv
package hzm_pkg;
  typedef enum logic {
    HZM_EDGE_RISE,
    HZM_EDGE_FALL
  } hzm_edge_t;
  typedef enum logic [1:0] {
    HZM_WD_HOLD,
    HZM_WD_RUN,
    HZM_WD_TRIP
  } hzm_wd_t;
endpackage
